// *** dv/mpsm_core_assertions.sv ***
`timescale 1ns/1ps
`include "mpsm_defs.vh"
module mpsm_core_chk (
  input wire clk_sys,
  input wire srst,
  input wire usb_attached,
  input wire usb_suspend,
  input wire host_ready,
  input wire wake_hold,
  input wire gpio_sleep_ok,
  input wire modem_sleep_ok,
  input wire [3:0] power_state,
  input wire [1:0] active_sub_mode,
  input wire app_core_run,
  input wire modem_run,
  input wire modem_drx,
  input wire wwan_radio_on,
  input wire context_retained,
  input wire area_update_pulse,
  input wire module_reset_pulse,
  input wire emergency_off_pulse
);
  wire act = power_state == `MPSM_ST_ACTIVE;
  wire slp = power_state == `MPSM_ST_SLEEP;
  wire ok = (!usb_attached | usb_suspend) & !host_ready & !wake_hold &
    gpio_sleep_ok & modem_sleep_ok;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_state_onehot: assert property ($onehot(power_state))
    else $error("power state not one-hot");
  a_app_active: assert property (app_core_run == act)
    else $error("app core run mismatch");
  a_modem_on: assert property (modem_run == (act | slp))
    else $error("modem run mismatch");
  a_drx_mode: assert property
    (modem_drx == (slp | act & active_sub_mode == `MPSM_SUB_EDRX))
    else $error("modem drx mismatch");
  a_radio_mode: assert property
    (wwan_radio_on == (slp | act & active_sub_mode != `MPSM_SUB_AIRPLANE))
    else $error("radio enable mismatch");
  a_ctx_keep: assert property
    (context_retained == (power_state != `MPSM_ST_OFF))
    else $error("context retain mismatch");
  a_sleep_cause: assert property ($rose(slp) |-> $past(ok))
    else $error("sleep entered without condition");
  a_upd_pulse: assert property
    (area_update_pulse |-> act ##1 !area_update_pulse)
    else $error("area update pulse wrong");
  a_emerg_off: assert property
    (emergency_off_pulse |-> power_state == `MPSM_ST_OFF)
    else $error("emergency off not in off");
  a_rst_wake: assert property (module_reset_pulse |-> act)
    else $error("reset pulse not in active");
endmodule
bind mpsm_core mpsm_core_chk i_chk (.*);

// *** dv/mpsm_host_model.sv ***
`timescale 1ns/1ps
module mpsm_host_model (
  input wire clk_sys,
  output logic power_applied,
  output logic pwr_on_req_n,
  output logic rst_req_n
);
  initial begin
    power_applied = 1'b0;
    pwr_on_req_n = 1'b1;
    rst_req_n = 1'b1;
  end
  task automatic supply(input logic on);
    @(posedge clk_sys) #1 power_applied = on;
  endtask
  // released line floats to its pull-up
  task automatic request_on(input logic on);
    @(posedge clk_sys) #1 pwr_on_req_n = !on;
  endtask
  // low pulse held well past the synchroniser
  task automatic reset_pulse();
    @(posedge clk_sys) #1 rst_req_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 rst_req_n = 1'b1;
  endtask
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ps
`include "mpsm_defs.vh"
module tb;
  logic clk_sys, srst, power_applied, pwr_on_req_n, rst_req_n;
  logic [1:0] sub_mode_sel, active_sub_mode;
  logic dormant_enable, usb_attached, usb_suspend, host_ready, wake_hold;
  logic gpio_sleep_ok, modem_sleep_ok, wake_trigger, data_activity;
  logic [31:0] periodic_cycle_timer, inactivity_period;
  logic [3:0] power_state;
  logic app_core_run, modem_run, modem_drx, wwan_radio_on;
  logic context_retained, area_update_pulse;
  logic module_reset_pulse, emergency_off_pulse;
  int errors = 0, tests_run = 0, n_upd = 0, n_rst = 0, n_off = 0, n0, t;
  mpsm_core i_mpsm_core (.*);
  mpsm_host_model u_host (.clk_sys(clk_sys), .power_applied(power_applied),
    .pwr_on_req_n(pwr_on_req_n), .rst_req_n(rst_req_n));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (area_update_pulse === 1'b1) n_upd++;
    if (module_reset_pulse === 1'b1) n_rst++;
    if (emergency_off_pulse === 1'b1) n_off++;
  end
  function automatic logic sleep_ok();
    return (!usb_attached | usb_suspend) & !host_ready & !wake_hold &
      gpio_sleep_ok & modem_sleep_ok;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wait_st(input logic [3:0] e, input int n);
    repeat (n) begin
      @(posedge clk_sys) #1;
      if (power_state === e) break;
    end
    chk("power_state", e, power_state);
  endtask
  task automatic close_out();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    close_out();
  end
  initial begin
    void'($urandom(32'ha2db));
    srst = 1'b1; sub_mode_sel = 2'h0; dormant_enable = 1'b0;
    periodic_cycle_timer = 32'h20 + {27'h0, 5'($urandom)};
    inactivity_period = 32'h10 + {28'h0, 4'($urandom)};
    usb_attached = 1'b1; usb_suspend = 1'b0; host_ready = 1'b1;
    wake_hold = 1'b0; gpio_sleep_ok = 1'b1; modem_sleep_ok = 1'b1;
    wake_trigger = 1'b0; data_activity = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 srst = 1'b0;
    chk("off_after_reset", `MPSM_ST_OFF, power_state);
    u_host.request_on(1'b1);
    u_host.supply(1'b1);
    wait_st(`MPSM_ST_ACTIVE, 20);
    for (int s = 0; s < 4; s++) begin
      sub_mode_sel = s[1:0];
      repeat (2) @(posedge clk_sys) #1;
      chk("sub_mode", s[1:0], active_sub_mode);
      chk("radio", s != 2, wwan_radio_on);
      chk("drx", s == 3, modem_drx);
    end
    // corner: all conditions met but a wake hold stays
    usb_suspend = 1'b1; host_ready = 1'b0; wake_hold = 1'b1;
    repeat (6) @(posedge clk_sys) #1;
    chk("hold_blocks_sleep", `MPSM_ST_ACTIVE, power_state);
    for (int i = 0; i < 24; i++) begin
      {usb_attached, usb_suspend, host_ready, wake_hold, gpio_sleep_ok,
        modem_sleep_ok} = 6'($urandom);
      sub_mode_sel = 2'($urandom);
      repeat (4) @(posedge clk_sys) #1;
      chk("sleep_rand", sleep_ok() ? `MPSM_ST_SLEEP : `MPSM_ST_ACTIVE,
        power_state);
      chk("modem_run", 1'b1, modem_run);
    end
    {usb_attached, host_ready, wake_hold, gpio_sleep_ok, modem_sleep_ok} = 5'h03;
    wait_st(`MPSM_ST_SLEEP, 8);
    wake_trigger = 1'b1;
    wait_st(`MPSM_ST_ACTIVE, 8);
    host_ready = 1'b1;
    wake_trigger = 1'b0;
    n0 = n_rst;
    u_host.reset_pulse();
    repeat (8) @(posedge clk_sys) #1;
    chk("reset_pulses", n0 + 1, n_rst);
    chk("reset_state", `MPSM_ST_ACTIVE, power_state);
    dormant_enable = 1'b1;
    u_host.request_on(1'b0);
    wait_st(`MPSM_ST_DORMANT, 60);
    chk("ctx", 1'b1, context_retained);
    n0 = n_upd;
    t = 0;
    while (n_upd == n0 && t < 100) begin
      @(posedge clk_sys) #1;
      t++;
    end
    chk("update_state", `MPSM_ST_ACTIVE, power_state);
    chk("update_early", 1'b1, t < periodic_cycle_timer);
    chk("update_late", 1'b1,
      t > periodic_cycle_timer - `MPSM_BOOT_MARGIN);
    data_activity = 1'b1;
    repeat (40) @(posedge clk_sys) #1;
    chk("data_hold", `MPSM_ST_ACTIVE, power_state);
    data_activity = 1'b0;
    wait_st(`MPSM_ST_DORMANT, 60);
    n0 = n_off;
    u_host.reset_pulse();
    repeat (8) @(posedge clk_sys) #1;
    chk("emergency", n0 + 1, n_off);
    chk("emergency_st", `MPSM_ST_OFF, power_state);
    u_host.request_on(1'b1);
    wait_st(`MPSM_ST_ACTIVE, 10);
    u_host.request_on(1'b0);
    u_host.supply(1'b0);
    wait_st(`MPSM_ST_OFF, 20);
    u_host.supply(1'b1);
    wait_st(`MPSM_ST_DORMANT, 20);
    u_host.request_on(1'b1);
    wait_st(`MPSM_ST_ACTIVE, 10);
    u_host.supply(1'b0);
    wait_st(`MPSM_ST_OFF, 20);
    close_out();
  end
endmodule

// *** rtl/mpsm_core.v ***
`timescale 1ns/1ps
`include "mpsm_defs.vh"

// Functional notes
// - exactly four power states: active, sleep, dormant, off; functions gated.
// - active runs one of four sub-modes: full, idle, airplane, eDRX.
// - sleep halts app core, modem in DRX, wake triggers watched.
// - sleep entry only on USB suspend or detach, DTR, no wake holds, GPIO, modem.
// - dormant is very low power, unreachable, registration context retained.
// - dormant period end boots modem and app, then sends area update.
// - after update stay active, return to dormant after inactivity period.
// - power applied: request asserted goes active, else goes dormant.
// - periodic cycle timer sets dormant length, used only in dormant.
// - wakeup timer is cycle timer minus margin, boot finishes first.
// - reset request with power-on asserted resets and wakes from dormant.
// - reset request without power-on asserted gives emergency power off.
// - power-on request assertion wakes module from off or dormant.
module mpsm_core (
  input wire clk_sys,
  input wire srst,
  input wire power_applied,
  input wire pwr_on_req_n,
  input wire rst_req_n,
  input wire [1:0] sub_mode_sel,
  input wire dormant_enable,
  input wire [31:0] periodic_cycle_timer,
  input wire [31:0] inactivity_period,
  input wire usb_attached,
  input wire usb_suspend,
  input wire host_ready,
  input wire wake_hold,
  input wire gpio_sleep_ok,
  input wire modem_sleep_ok,
  input wire wake_trigger,
  input wire data_activity,
  output reg [3:0] power_state,
  output reg [1:0] active_sub_mode,
  output reg app_core_run,
  output reg modem_run,
  output reg modem_drx,
  output reg wwan_radio_on,
  output reg context_retained,
  output reg area_update_pulse,
  output reg module_reset_pulse,
  output reg emergency_off_pulse
);

  // ****************************************
  // input synchronisers
  // ****************************************
  wire pwr_on_n_s;
  wire rst_n_s;
  wire applied_s;

  mpsm_sync u_sync_pwr (
    .clk_sys(clk_sys),
    .srst(srst),
    .din(pwr_on_req_n),
    .dout(pwr_on_n_s)
  );

  mpsm_sync u_sync_rst (
    .clk_sys(clk_sys),
    .srst(srst),
    .din(rst_req_n),
    .dout(rst_n_s)
  );

  mpsm_sync u_sync_app (
    .clk_sys(clk_sys),
    .srst(srst),
    .din(~power_applied),
    .dout(applied_s)
  );

  wire pwr_on = ~pwr_on_n_s;
  wire rst_req = ~rst_n_s;
  wire powered = ~applied_s;

  reg rst_req_d_reg;
  reg pwr_on_d_reg;
  reg powered_d_reg;
  wire rst_rise = rst_req & ~rst_req_d_reg;
  wire pwr_rise = pwr_on & ~pwr_on_d_reg;
  // off is left only when power arrives or on a fresh power-on request
  wire power_rise = powered & ~powered_d_reg;

  // ****************************************
  // state machine
  // ****************************************
  localparam ST_OFF = `MPSM_ST_OFF;
  localparam ST_ACTIVE = `MPSM_ST_ACTIVE;
  localparam ST_SLEEP = `MPSM_ST_SLEEP;
  localparam ST_DORMANT = `MPSM_ST_DORMANT;

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [31:0] tmr_reg;
  reg [31:0] tmr_next;
  reg booting_reg;
  reg booting_next;
  reg [31:0] boot_reg;
  reg [31:0] boot_next;
  reg tau_next;
  reg mrst_next;
  reg eoff_next;

  // wakeup timer: shorter than the cycle timer by the boot margin, or one when the cycle timer does not exceed the margin
  wire [31:0] wake_time = (periodic_cycle_timer > `MPSM_BOOT_MARGIN) ?
    (periodic_cycle_timer - `MPSM_BOOT_MARGIN) : `MPSM_TMR_ONE;

  wire usb_ok = ~usb_attached | usb_suspend;
  wire sleep_ok = usb_ok & ~host_ready & ~wake_hold & gpio_sleep_ok &
    modem_sleep_ok;

  always @* begin
    state_next = state_reg;
    tmr_next = tmr_reg;
    booting_next = booting_reg;
    boot_next = boot_reg;
    tau_next = 1'b0;
    mrst_next = 1'b0;
    eoff_next = 1'b0;
    case (state_reg)
      ST_OFF: begin
        tmr_next = `MPSM_TMR_ZERO;
        if (power_rise) begin
          if (pwr_on) begin
            state_next = ST_ACTIVE;
          end else begin
            state_next = ST_DORMANT;
          end
        end else if (powered && pwr_rise) begin
          state_next = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (rst_rise && !pwr_on) begin
          eoff_next = 1'b1;
          state_next = ST_OFF;
        end else if (rst_rise) begin
          mrst_next = 1'b1;
          tmr_next = `MPSM_TMR_ZERO;
          booting_next = 1'b0;
        end else if (booting_reg) begin
          // boot in progress, then area update
          if (boot_reg >= `MPSM_BOOT_CYC) begin
            booting_next = 1'b0;
            tau_next = 1'b1;
            tmr_next = `MPSM_TMR_ZERO;
          end else begin
            boot_next = boot_reg + `MPSM_STEP;
          end
        end else if (data_activity) begin
          tmr_next = `MPSM_TMR_ZERO;
        end else if (dormant_enable && !pwr_on &&
                     tmr_reg >= inactivity_period) begin
          state_next = ST_DORMANT;
          tmr_next = `MPSM_TMR_ZERO;
        end else if (sleep_ok) begin
          state_next = ST_SLEEP;
        end else begin
          tmr_next = tmr_reg + `MPSM_STEP;
        end
      end
      ST_SLEEP: begin
        if (rst_rise && !pwr_on) begin
          eoff_next = 1'b1;
          state_next = ST_OFF;
        end else if (wake_trigger || !sleep_ok || rst_rise) begin
          state_next = ST_ACTIVE;
          tmr_next = `MPSM_TMR_ZERO;
          mrst_next = rst_rise;
        end
      end
      ST_DORMANT: begin
        // cycle timer counts here; the same tmr_reg also counts inactivity in active
        tmr_next = tmr_reg + `MPSM_STEP;
        if (rst_rise && !pwr_on) begin
          eoff_next = 1'b1;
          state_next = ST_OFF;
        end else if (rst_rise || pwr_rise || pwr_on) begin
          state_next = ST_ACTIVE;
          mrst_next = rst_rise;
          tmr_next = `MPSM_TMR_ZERO;
        end else if (tmr_reg >= wake_time) begin
          state_next = ST_ACTIVE;
          booting_next = 1'b1;
          boot_next = `MPSM_TMR_ZERO;
          tmr_next = `MPSM_TMR_ZERO;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
    if (!powered) begin
      state_next = ST_OFF;
      booting_next = 1'b0;
      tau_next = 1'b0;
      mrst_next = 1'b0;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= ST_OFF;
      tmr_reg <= `MPSM_TMR_ZERO;
      booting_reg <= 1'b0;
      boot_reg <= `MPSM_TMR_ZERO;
      rst_req_d_reg <= 1'b0;
      pwr_on_d_reg <= 1'b0;
      powered_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      booting_reg <= booting_next;
      boot_reg <= boot_next;
      rst_req_d_reg <= rst_req;
      pwr_on_d_reg <= pwr_on;
      powered_d_reg <= powered;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always @(posedge clk_sys) begin
    if (srst) begin
      power_state <= `MPSM_ST_OFF;
      active_sub_mode <= `MPSM_SUB_FULL;
      app_core_run <= 1'b0;
      modem_run <= 1'b0;
      modem_drx <= 1'b0;
      wwan_radio_on <= 1'b0;
      context_retained <= 1'b0;
      area_update_pulse <= 1'b0;
      module_reset_pulse <= 1'b0;
      emergency_off_pulse <= 1'b0;
    end else begin
      power_state <= state_next;
      active_sub_mode <= sub_mode_sel;
      app_core_run <= (state_next == ST_ACTIVE);
      modem_run <= (state_next == ST_ACTIVE) ||
        (state_next == ST_SLEEP);
      modem_drx <= (state_next == ST_SLEEP) ||
        ((state_next == ST_ACTIVE) &&
         (sub_mode_sel == `MPSM_SUB_EDRX));
      wwan_radio_on <= ((state_next == ST_ACTIVE) &&
        (sub_mode_sel != `MPSM_SUB_AIRPLANE)) ||
        (state_next == ST_SLEEP);
      // context held through dormant, dropped only at off
      context_retained <= (state_next != ST_OFF);
      area_update_pulse <= tau_next;
      module_reset_pulse <= mrst_next;
      emergency_off_pulse <= eoff_next;
    end
  end

endmodule

// *** rtl/mpsm_defs.vh ***
`ifndef MPSM_DEFS_VH
`define MPSM_DEFS_VH

// top-level power states, one-hot
`define MPSM_ST_OFF     4'h1
`define MPSM_ST_ACTIVE  4'h2
`define MPSM_ST_SLEEP   4'h4
`define MPSM_ST_DORMANT 4'h8

// active sub-modes
`define MPSM_SUB_FULL     2'h0
`define MPSM_SUB_IDLE     2'h1
`define MPSM_SUB_AIRPLANE 2'h2
`define MPSM_SUB_EDRX     2'h3

// timer widths and reset values
`define MPSM_TMR_W       32
`define MPSM_TMR_ZERO    32'h0000_0000
`define MPSM_TMR_ONE     32'h0000_0001
`define MPSM_STEP        32'h0000_0001
// boot margin of the wakeup timer ahead of the cycle timer, in cycles
`define MPSM_BOOT_MARGIN 32'h0000_0010
// cycles the boot sequence takes before the area update goes out
`define MPSM_BOOT_CYC    32'h0000_0008

// synchroniser reset level for active-low inputs
`define MPSM_SYNC_IDLE   3'h7

`endif

// *** rtl/mpsm_sync.v ***
`timescale 1ns/1ps
`include "mpsm_defs.vh"

// three-stage synchroniser; output changes when stages two and three agree
module mpsm_sync (
  input wire clk_sys,
  input wire srst,
  input wire din,
  output reg dout
);

  reg [2:0] sync_reg;

  always @(posedge clk_sys) begin
    if (srst) begin
      sync_reg <= `MPSM_SYNC_IDLE;
      dout <= 1'b1;
    end else begin
      sync_reg <= {sync_reg[1:0], din};
      if (sync_reg[1] == sync_reg[2]) begin
        dout <= sync_reg[2];
      end
    end
  end

endmodule
